// >>> shared/irq_cfg.svh
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH

// Register indices; byte address is four times the index
`define GEN_CTRL_IDX 6'h35
`define TFLAG_IDX 6'h38
`define TMASK_IDX 6'h39
`define EXT_FLAG_IDX 6'h3A
`define EXT_EN_IDX 6'h3B
`define STATUS_IDX 6'h3F

// Timer flag and mask bit positions
`define T2_CMP_BIT 7
`define T2_OVF_BIT 6
`define T1_CAP_BIT 5
`define T1_CMPA_BIT 4
`define T1_CMPB_BIT 3
`define T1_OVF_BIT 2
`define TIMER_RSVD_BIT 1
`define T0_OVF_BIT 0
`define TIMER_BITS_MASK 8'hFD

// General control bit positions
`define SLEEP_ARM_BIT 6
`define SLEEP_KIND_HI 5
`define SLEEP_KIND_LO 4
`define EXT1_SENSE_HI 3
`define EXT1_SENSE_LO 2
`define EXT0_SENSE_HI 1
`define EXT0_SENSE_LO 0
`define GEN_CTRL_MASK 8'h7F

// External enable/flag and status bit positions
`define EXT1_BIT 7
`define EXT0_BIT 6
`define GIE_BIT 7

// Reset values
`define GEN_CTRL_RST 8'h00
`define TIMER_REG_RST 8'h00
`define EXT_REG_RST 2'h0

// Vector addresses
`define VEC_NONE 4'h0
`define VEC_EXT0 4'h1
`define VEC_EXT1 4'h2
`define VEC_T2_CMP 4'h3
`define VEC_T2_OVF 4'h4
`define VEC_T1_CAP 4'h5
`define VEC_T1_CMPA 4'h6
`define VEC_T1_CMPB 4'h7
`define VEC_T1_OVF 4'h8
`define VEC_T0_OVF 4'h9

// Sequence lengths in clock cycles, and first/last push or pop cycle within a sequence
`define ENTRY_CYCLES 3'h4
`define JUMP_CYCLES 3'h2
`define RETURN_CYCLES 3'h4
`define PUSH_FIRST 3'h1
`define PUSH_LAST 3'h2

// AXI responses
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// >>> shared/irq_pkg.sv
package irq_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ENTRY = 3'h1,
		ST_JUMP = 3'h3,
		ST_HANDLER = 3'h2,
		ST_RETURN = 3'h6,
		ST_SETTLE = 3'h7
	} ctrl_state_t;

	typedef enum logic [1:0] {
		SLEEP_IDLE = 2'h0,
		SLEEP_RSVD = 2'h1,
		SLEEP_PDOWN = 2'h2,
		SLEEP_PSAVE = 2'h3
	} sleep_mode_t;

	typedef enum logic [1:0] {
		SENSE_LOW = 2'h0,
		SENSE_RSVD = 2'h1,
		SENSE_FALL = 2'h2,
		SENSE_RISE = 2'h3
	} sense_t;

endpackage

// >>> core/ext_sense.sv
`timescale 1ns/1ps
module ext_sense
	import irq_pkg::*;
(
	input wire logic clk_in, // System clock
	input wire logic arst_n_in, // Async reset, active low
	input wire logic pin_in, // Raw pin level
	input wire logic [1:0] sense_in, // Sense code
	output logic edge_hit_out, // One-cycle edge event
	output logic level_req_out // Held while pin low in level mode
);

	logic sync1_r;
	logic sync2_r;
	logic prev_r;
	sense_t sense;

	assign sense = sense_t'(sense_in);

	// Pin read even when driven as output, so software can trigger it
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			sync1_r <= pin_in; // R12
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	always_comb begin
		edge_hit_out = 1'b0;
		level_req_out = 1'b0;
		case (sense)
			SENSE_LOW: level_req_out = ~sync2_r; // R13 R24
			SENSE_FALL: edge_hit_out = prev_r & ~sync2_r; // R24
			SENSE_RISE: edge_hit_out = ~prev_r & sync2_r; // R24
			default: begin
				edge_hit_out = 1'b0;
				level_req_out = 1'b0;
			end
		endcase
	end

endmodule

// >>> core/irq_flags_vectoring_sleep_ctrl.sv
`timescale 1ns/1ps
`include "irq_cfg.svh"
// Notes on behaviour
// R1: Timer1 compare-B requests vector 7 when enabled
// R2: Timer1 overflow requests vector 8 when enabled
// R3: Timer0 overflow requests vector 9 when enabled
// R4: Flag register layout bits 7..2 and 0
// R5: Bit 1 of mask and flags reads zero
// R6: Flags clear on vector fetch or write-one
// R7: Timer2 compare sets flag; needs flag, enable, global
// R8: Timer2 overflow flag; PWM uses bottom reversal
// R9: Capture event sets timer1 capture flag
// R10: Timer1 compare A/B set own flags
// R11: Timer1/timer0 overflow flags; timer1 PWM bottom
// R12: External pin triggers even when driven output
// R13: Level sense requests while pin held low
// R14: Entry four cycles, two pushes of PC
// R15: Vector jump takes two cycles
// R16: Finish current instruction before entry
// R17: Return four cycles, two pops of PC
// R18: One main instruction before next interrupt
// R19: Status word never saved or restored
// R20: Flags set on event edge only
// R21: General control register bit layout
// R22: Sleep entered only when sleep armed
// R23: Sleep kind codes idle, power down, save
// R24: Sense codes low, falling, rising edge
// R25: Accepting interrupt clears global enable
// R26: Lowest pending vector served first
module irq_flags_vectoring_sleep_ctrl
	import irq_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic CLK_SYS_IN, // 200 MHz system clock
	input wire logic ARST_N_IN, // Async reset, active low
	input wire logic [ADDR_W-1:0] AWADDR_IN, // AXI write address
	input wire logic AWVALID_IN, // AXI write address valid
	output logic AWREADY_OUT, // AXI write address ready
	input wire logic [31:0] WDATA_IN, // AXI write data
	input wire logic [3:0] WSTRB_IN, // AXI write strobes
	input wire logic WVALID_IN, // AXI write data valid
	output logic WREADY_OUT, // AXI write data ready
	output logic [1:0] BRESP_OUT, // AXI write response
	output logic BVALID_OUT, // AXI write response valid
	input wire logic BREADY_IN, // AXI write response ready
	input wire logic [ADDR_W-1:0] ARADDR_IN, // AXI read address
	input wire logic ARVALID_IN, // AXI read address valid
	output logic ARREADY_OUT, // AXI read address ready
	output logic [31:0] RDATA_OUT, // AXI read data
	output logic [1:0] RRESP_OUT, // AXI read response
	output logic RVALID_OUT, // AXI read data valid
	input wire logic RREADY_IN, // AXI read data ready
	input wire logic T2_CMP_MATCH_IN, // Timer2 equals compare value
	input wire logic T2_OVF_IN, // Timer2 overflow
	input wire logic T2_BOTTOM_IN, // Timer2 reverses at zero
	input wire logic T2_PWM_IN, // Timer2 in PWM mode
	input wire logic T1_CAPTURE_IN, // Timer1 capture stored
	input wire logic T1_CMPA_MATCH_IN, // Timer1 equals compare A
	input wire logic T1_CMPB_MATCH_IN, // Timer1 equals compare B
	input wire logic T1_OVF_IN, // Timer1 overflow
	input wire logic T1_BOTTOM_IN, // Timer1 reverses at zero
	input wire logic T1_PWM_IN, // Timer1 in PWM mode
	input wire logic T0_OVF_IN, // Timer0 overflow
	input wire logic EXT_IRQ_PIN_0_IN, // External interrupt pin 0
	input wire logic EXT_IRQ_PIN_1_IN, // External interrupt pin 1
	input wire logic INSTR_DONE_IN, // Core at instruction boundary
	input wire logic RETI_IN, // Core executes return from handler
	input wire logic SLEEP_INSTR_IN, // Core executes sleep
	output logic IRQ_PENDING_OUT, // Enabled request waiting
	output logic VECTOR_FETCH_OUT, // Core jumps to vector now
	output logic [3:0] VECTOR_ADDR_OUT, // Vector address
	output logic STACK_PUSH_OUT, // Push one PC byte, SP minus one
	output logic STACK_POP_OUT, // Pop one PC byte, SP plus one
	output logic GLOBAL_IRQ_EN_OUT, // Global interrupt enable
	output logic SLEEP_ACTIVE_OUT, // Core asleep
	output logic [1:0] SLEEP_MODE_OUT // Selected sleep kind
);

	logic [7:0] general_control_r;
	logic [7:0] timer_event_flags_r;
	logic [7:0] timer_event_flags_nxt;
	logic [7:0] timer_event_mask_r;
	logic [1:0] ext_flags_r;
	logic [1:0] ext_flags_nxt;
	logic [1:0] ext_en_r;
	logic gie_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;
	logic wr_fire;
	logic wr_en;
	logic rd_fire;
	logic [5:0] wr_idx;
	logic [5:0] rd_idx;
	logic [7:0] wbyte;
	logic [7:0] ev_lvl;
	logic [7:0] ev_prev_r;
	logic [7:0] ev_rise;
	logic [7:0] timer_pend;
	logic [1:0] ext_edge;
	logic [1:0] ext_level;
	logic [1:0] ext_pend;
	logic [9:1] vec_pend;
	logic [3:0] pick;
	logic accept;
	logic fetch_now;
	logic [7:0] hw_clr_tim;
	logic [1:0] hw_clr_ext;
	ctrl_state_t state_r;
	logic [2:0] cnt_r;
	logic [3:0] vec_r;
	logic fetch_r;
	logic push_r;
	logic pop_r;
	logic sleep_r;
	logic [1:0] sleep_mode_r;
	logic [7:0] rd_byte;
	logic rd_hit;

	// Write channel: both halves taken together, one write in flight
	assign wr_fire = AWVALID_IN & WVALID_IN & ~bvalid_r;
	assign AWREADY_OUT = wr_fire;
	assign WREADY_OUT = wr_fire;
	assign wr_idx = AWADDR_IN[7:2];
	assign wr_en = wr_fire & WSTRB_IN[0];
	assign wbyte = WDATA_IN[7:0];
	assign rd_fire = ARVALID_IN & ~rvalid_r;
	assign ARREADY_OUT = ~rvalid_r;
	assign rd_idx = ARADDR_IN[7:2];

	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			bvalid_r <= 1'b0;
			bresp_r <= `AXI_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			case (wr_idx)
				`GEN_CTRL_IDX, `TFLAG_IDX, `TMASK_IDX, `EXT_FLAG_IDX, `EXT_EN_IDX, `STATUS_IDX: begin
					bresp_r <= `AXI_OKAY;
				end
				default: bresp_r <= `AXI_SLVERR;
			endcase
		end else if (BREADY_IN) begin
			bvalid_r <= 1'b0;
		end
	end

	assign BVALID_OUT = bvalid_r;
	assign BRESP_OUT = bresp_r;

	always_comb begin
		rd_byte = 8'h00;
		rd_hit = 1'b1;
		case (rd_idx)
			`GEN_CTRL_IDX: rd_byte = general_control_r & `GEN_CTRL_MASK; // R21
			`TFLAG_IDX: rd_byte = timer_event_flags_r & `TIMER_BITS_MASK; // R5
			`TMASK_IDX: rd_byte = timer_event_mask_r & `TIMER_BITS_MASK; // R5
			`EXT_FLAG_IDX: rd_byte = {ext_flags_r[1], ext_flags_r[0], 6'h00};
			`EXT_EN_IDX: rd_byte = {ext_en_r[1], ext_en_r[0], 6'h00};
			`STATUS_IDX: rd_byte = {gie_r, 7'h00};
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rvalid_r <= 1'b0;
			rresp_r <= `AXI_OKAY;
			rdata_r <= 32'h0000_0000;
		end else if (rd_fire) begin
			rvalid_r <= 1'b1;
			rresp_r <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
			rdata_r <= {24'h00_0000, rd_byte};
		end else if (RREADY_IN) begin
			rvalid_r <= 1'b0;
		end
	end

	assign RVALID_OUT = rvalid_r;
	assign RRESP_OUT = rresp_r;
	assign RDATA_OUT = rdata_r;

	// Plain control registers
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			general_control_r <= `GEN_CTRL_RST;
			timer_event_mask_r <= `TIMER_REG_RST;
			ext_en_r <= `EXT_REG_RST;
		end else if (wr_en) begin
			if (wr_idx == `GEN_CTRL_IDX) begin
				general_control_r <= wbyte & `GEN_CTRL_MASK; // R21
			end
			if (wr_idx == `TMASK_IDX) begin
				timer_event_mask_r <= wbyte & `TIMER_BITS_MASK; // R5
			end
			if (wr_idx == `EXT_EN_IDX) begin
				ext_en_r <= {wbyte[`EXT1_BIT], wbyte[`EXT0_BIT]};
			end
		end
	end

	// Standing conditions only flag on their leading edge
	always_comb begin
		ev_lvl = 8'h00;
		ev_lvl[`T2_CMP_BIT] = T2_CMP_MATCH_IN; // R7
		ev_lvl[`T2_OVF_BIT] = T2_PWM_IN ? T2_BOTTOM_IN : T2_OVF_IN; // R8
		ev_lvl[`T1_CAP_BIT] = T1_CAPTURE_IN; // R9
		ev_lvl[`T1_CMPA_BIT] = T1_CMPA_MATCH_IN; // R10
		ev_lvl[`T1_CMPB_BIT] = T1_CMPB_MATCH_IN; // R10
		ev_lvl[`T1_OVF_BIT] = T1_PWM_IN ? T1_BOTTOM_IN : T1_OVF_IN; // R11
		ev_lvl[`T0_OVF_BIT] = T0_OVF_IN; // R11
	end

	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ev_prev_r <= 8'h00;
		end else begin
			ev_prev_r <= ev_lvl;
		end
	end

	assign ev_rise = ev_lvl & ~ev_prev_r & `TIMER_BITS_MASK; // R20 R4

	// Vector-to-flag map for the hardware clear at fetch
	always_comb begin
		hw_clr_tim = 8'h00;
		hw_clr_ext = 2'h0;
		if (fetch_now) begin
			case (vec_r)
				`VEC_EXT0: hw_clr_ext[0] = 1'b1;
				`VEC_EXT1: hw_clr_ext[1] = 1'b1;
				`VEC_T2_CMP: hw_clr_tim[`T2_CMP_BIT] = 1'b1;
				`VEC_T2_OVF: hw_clr_tim[`T2_OVF_BIT] = 1'b1;
				`VEC_T1_CAP: hw_clr_tim[`T1_CAP_BIT] = 1'b1;
				`VEC_T1_CMPA: hw_clr_tim[`T1_CMPA_BIT] = 1'b1;
				`VEC_T1_CMPB: hw_clr_tim[`T1_CMPB_BIT] = 1'b1;
				`VEC_T1_OVF: hw_clr_tim[`T1_OVF_BIT] = 1'b1;
				`VEC_T0_OVF: hw_clr_tim[`T0_OVF_BIT] = 1'b1;
				default: hw_clr_tim = 8'h00;
			endcase
		end
	end

	// New event wins over a clear in the same cycle
	always_comb begin
		timer_event_flags_nxt = timer_event_flags_r & ~hw_clr_tim; // R6
		ext_flags_nxt = ext_flags_r & ~hw_clr_ext;
		if (wr_en && wr_idx == `TFLAG_IDX) begin
			timer_event_flags_nxt = timer_event_flags_nxt & ~wbyte; // R6
		end
		if (wr_en && wr_idx == `EXT_FLAG_IDX) begin
			ext_flags_nxt = ext_flags_nxt & ~{wbyte[`EXT1_BIT], wbyte[`EXT0_BIT]};
		end
		timer_event_flags_nxt = (timer_event_flags_nxt | ev_rise) & `TIMER_BITS_MASK; // R4 R5
		ext_flags_nxt = ext_flags_nxt | ext_edge;
	end

	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			timer_event_flags_r <= `TIMER_REG_RST;
			ext_flags_r <= `EXT_REG_RST;
		end else begin
			timer_event_flags_r <= timer_event_flags_nxt;
			ext_flags_r <= ext_flags_nxt;
		end
	end

	ext_sense u_ext0 (
		.clk_in(CLK_SYS_IN),
		.arst_n_in(ARST_N_IN),
		.pin_in(EXT_IRQ_PIN_0_IN),
		.sense_in(general_control_r[`EXT0_SENSE_HI:`EXT0_SENSE_LO]),
		.edge_hit_out(ext_edge[0]),
		.level_req_out(ext_level[0])
	);

	ext_sense u_ext1 (
		.clk_in(CLK_SYS_IN),
		.arst_n_in(ARST_N_IN),
		.pin_in(EXT_IRQ_PIN_1_IN),
		.sense_in(general_control_r[`EXT1_SENSE_HI:`EXT1_SENSE_LO]),
		.edge_hit_out(ext_edge[1]),
		.level_req_out(ext_level[1])
	);

	// Level mode has no flag; the request follows the pin
	assign ext_pend = ext_en_r & (ext_flags_r | ext_level); // R13
	assign timer_pend = timer_event_flags_r & timer_event_mask_r; // R7 R10

	always_comb begin
		vec_pend[`VEC_EXT0] = ext_pend[0];
		vec_pend[`VEC_EXT1] = ext_pend[1];
		vec_pend[`VEC_T2_CMP] = timer_pend[`T2_CMP_BIT]; // R7
		vec_pend[`VEC_T2_OVF] = timer_pend[`T2_OVF_BIT];
		vec_pend[`VEC_T1_CAP] = timer_pend[`T1_CAP_BIT];
		vec_pend[`VEC_T1_CMPA] = timer_pend[`T1_CMPA_BIT];
		vec_pend[`VEC_T1_CMPB] = timer_pend[`T1_CMPB_BIT]; // R1
		vec_pend[`VEC_T1_OVF] = timer_pend[`T1_OVF_BIT]; // R2
		vec_pend[`VEC_T0_OVF] = timer_pend[`T0_OVF_BIT]; // R3
	end

	// Scan downward so the lowest vector is left standing
	always_comb begin
		pick = `VEC_NONE;
		for (int i = 9; i >= 1; i--) begin
			if (vec_pend[i]) begin
				pick = 4'(i); // R26
			end
		end
	end

	assign IRQ_PENDING_OUT = |vec_pend;
	// Asleep counts as a boundary; awake waits for the instruction to end
	assign accept = (state_r == ST_IDLE) && gie_r && (|vec_pend) && (INSTR_DONE_IN || sleep_r); // R16 R1 R2 R3
	assign fetch_now = (state_r == ST_ENTRY) && (cnt_r == `ENTRY_CYCLES - 3'h1);

	// Sequencer; the core's status word is left to handler code
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin // R19
		if (!ARST_N_IN) begin
			state_r <= ST_IDLE;
			cnt_r <= 3'h0;
			vec_r <= `VEC_NONE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (accept) begin
						state_r <= ST_ENTRY;
						cnt_r <= 3'h0;
						vec_r <= pick; // R26
					end
				end
				ST_ENTRY: begin
					cnt_r <= cnt_r + 3'h1;
					if (fetch_now) begin
						state_r <= ST_JUMP; // R14
						cnt_r <= 3'h0;
					end
				end
				ST_JUMP: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == `JUMP_CYCLES - 3'h1) begin
						state_r <= ST_HANDLER; // R15
						cnt_r <= 3'h0;
					end
				end
				ST_HANDLER: begin
					if (RETI_IN) begin
						state_r <= ST_RETURN;
						cnt_r <= 3'h0;
					end
				end
				ST_RETURN: begin
					cnt_r <= cnt_r + 3'h1;
					if (cnt_r == `RETURN_CYCLES - 3'h1) begin
						state_r <= ST_SETTLE; // R17
						cnt_r <= 3'h0;
					end
				end
				ST_SETTLE: begin
					if (INSTR_DONE_IN) begin
						state_r <= ST_IDLE; // R18
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Strobes to the core, one byte of PC per push or pop
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			fetch_r <= 1'b0;
			push_r <= 1'b0;
			pop_r <= 1'b0;
		end else begin
			fetch_r <= fetch_now; // R14
			push_r <= (state_r == ST_ENTRY) && (cnt_r >= `PUSH_FIRST) && (cnt_r <= `PUSH_LAST); // R14
			pop_r <= (state_r == ST_RETURN) && (cnt_r >= `PUSH_FIRST) && (cnt_r <= `PUSH_LAST); // R17
		end
	end

	assign VECTOR_FETCH_OUT = fetch_r;
	assign VECTOR_ADDR_OUT = vec_r;
	assign STACK_PUSH_OUT = push_r;
	assign STACK_POP_OUT = pop_r;

	// Acceptance clear beats a software set in the same cycle
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			gie_r <= 1'b0;
		end else if (accept) begin
			gie_r <= 1'b0; // R25
		end else if (state_r == ST_RETURN && cnt_r == `RETURN_CYCLES - 3'h1) begin
			gie_r <= 1'b1;
		end else if (wr_en && wr_idx == `STATUS_IDX) begin
			gie_r <= wbyte[`GIE_BIT];
		end
	end

	assign GLOBAL_IRQ_EN_OUT = gie_r;

	// Any enabled request wakes the core, global enable or not
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			sleep_r <= 1'b0;
			sleep_mode_r <= SLEEP_IDLE;
		end else if (sleep_r && (|vec_pend)) begin
			sleep_r <= 1'b0;
		end else if (SLEEP_INSTR_IN && general_control_r[`SLEEP_ARM_BIT] && state_r == ST_IDLE) begin
			sleep_r <= 1'b1; // R22
			sleep_mode_r <= general_control_r[`SLEEP_KIND_HI:`SLEEP_KIND_LO]; // R23
		end
	end

	assign SLEEP_ACTIVE_OUT = sleep_r;
	assign SLEEP_MODE_OUT = sleep_mode_r;

endmodule

// >>> test/irq_core_model.sv
`timescale 1ns/1ps
module irq_core_model (
	input wire logic clk_in, // System clock
	input wire logic arst_n_in, // Async reset, active low
	input wire logic fetch_in, // Vector fetch pulse
	output logic instr_done_out, // Instruction boundary pulse
	output logic reti_out // Return from handler pulse
);
	logic [1:0] phase_r;
	logic [3:0] hand_r;
	// Four-cycle instructions, so entry must wait for a boundary
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			phase_r <= 2'h0;
			instr_done_out <= 1'h0;
		end else begin
			phase_r <= phase_r + 2'h1;
			instr_done_out <= (phase_r == 2'h2);
		end
	end
	// Handler body long enough to clear the two jump cycles
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hand_r <= 4'h0;
			reti_out <= 1'h0;
		end else begin
			hand_r <= fetch_in ? 4'h6 : (hand_r != 4'h0) ? hand_r - 4'h1 : 4'h0;
			reti_out <= (hand_r == 4'h1);
		end
	end
endmodule

// >>> test/irq_ctrl_assertions.sv
`timescale 1ns/1ps
module irq_ctrl_assertions (
	input wire logic CLK_SYS_IN, // Clock
	input wire logic ARST_N_IN, // Reset
	input wire logic AWVALID_IN, // Write address valid
	input wire logic AWREADY_OUT, // Write address ready
	input wire logic BVALID_OUT, // Write response valid
	input wire logic BREADY_IN, // Write response ready
	input wire logic [1:0] BRESP_OUT, // Write response
	input wire logic ARVALID_IN, // Read address valid
	input wire logic ARREADY_OUT, // Read address ready
	input wire logic RVALID_OUT, // Read valid
	input wire logic [31:0] RDATA_OUT, // Read data
	input wire logic VECTOR_FETCH_OUT, // Fetch pulse
	input wire logic [3:0] VECTOR_ADDR_OUT, // Vector
	input wire logic STACK_PUSH_OUT, // Push
	input wire logic STACK_POP_OUT, // Pop
	input wire logic GLOBAL_IRQ_EN_OUT, // Global enable
	input wire logic RETI_IN, // Return
	input wire logic INSTR_DONE_IN, // Boundary
	input wire logic SLEEP_INSTR_IN, // Sleep instruction
	input wire logic SLEEP_ACTIVE_OUT, // Asleep
	input wire logic IRQ_PENDING_OUT // Pending request
);
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!ARST_N_IN);
	logic ret_wait_r;
	always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) ret_wait_r <= 1'h0;
		else if (STACK_POP_OUT) ret_wait_r <= 1'h1;
		else if (INSTR_DONE_IN && GLOBAL_IRQ_EN_OUT) ret_wait_r <= 1'h0;
	end
	property p_bvalid; AWVALID_IN && AWREADY_OUT |=> BVALID_OUT; endproperty
	a_bvalid: assert property (p_bvalid) else $error("write not answered");
	property p_bhold; BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT); endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rdata; ARVALID_IN && ARREADY_OUT |=> RVALID_OUT && RDATA_OUT[31:8] == 24'h000000; endproperty
	a_rdata: assert property (p_rdata) else $error("read answer wrong");
	property p_entry;
		$fell(GLOBAL_IRQ_EN_OUT) |-> !STACK_PUSH_OUT ##1 !STACK_PUSH_OUT ##1 STACK_PUSH_OUT[*2]
			##1 VECTOR_FETCH_OUT && !STACK_PUSH_OUT;
	endproperty
	a_entry: assert property (p_entry) else $error("entry sequence wrong");
	property p_jump; VECTOR_FETCH_OUT |=> (!VECTOR_FETCH_OUT && !STACK_PUSH_OUT && !STACK_POP_OUT)[*2]; endproperty
	a_jump: assert property (p_jump) else $error("jump cycles disturbed");
	property p_fetch; VECTOR_FETCH_OUT |-> !GLOBAL_IRQ_EN_OUT && VECTOR_ADDR_OUT inside {[4'h1:4'h9]}; endproperty
	a_fetch: assert property (p_fetch) else $error("fetch with enable set");
	property p_ret;
		RETI_IN |=> !STACK_POP_OUT[*2] ##1 (STACK_POP_OUT && !GLOBAL_IRQ_EN_OUT)[*2]
			##1 !STACK_POP_OUT && GLOBAL_IRQ_EN_OUT;
	endproperty
	a_ret: assert property (p_ret) else $error("return sequence wrong");
	property p_settle; ret_wait_r && INSTR_DONE_IN && GLOBAL_IRQ_EN_OUT |=> GLOBAL_IRQ_EN_OUT; endproperty
	a_settle: assert property (p_settle) else $error("served before one instruction");
	property p_sleep; $rose(SLEEP_ACTIVE_OUT) |-> $past(SLEEP_INSTR_IN); endproperty
	a_sleep: assert property (p_sleep) else $error("slept without instruction");
	property p_wake; SLEEP_ACTIVE_OUT && IRQ_PENDING_OUT |=> !SLEEP_ACTIVE_OUT; endproperty
	a_wake: assert property (p_wake) else $error("no wake on request");
endmodule

// >>> test/irq_flags_vectoring_sleep_ctrl_test.sv
`timescale 1ns/1ps
module irq_flags_vectoring_sleep_ctrl_test;
	logic clk, rst_n, awv, wv, br, arv, rr, sl, t1p, t2p, p0, p1;
	logic awr, wrdy, bv, arr, rv, pend, fet, push, pop, gie, slp, idone, reti;
	logic [7:0] awa, ara;
	logic [31:0] wd, rdata;
	logic [9:0] ev;
	logic [1:0] bresp, rresp, smode;
	logic [3:0] vaddr;
	int err_count, checked;
	irq_flags_vectoring_sleep_ctrl irq_flags_vectoring_sleep_ctrl_i (.CLK_SYS_IN(clk), .ARST_N_IN(rst_n),
		.AWADDR_IN(awa), .AWVALID_IN(awv), .AWREADY_OUT(awr), .WDATA_IN(wd), .WSTRB_IN(4'hF), .WVALID_IN(wv),
		.WREADY_OUT(wrdy), .BRESP_OUT(bresp), .BVALID_OUT(bv), .BREADY_IN(br), .ARADDR_IN(ara), .ARVALID_IN(arv),
		.ARREADY_OUT(arr), .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rv), .RREADY_IN(rr),
		.T2_CMP_MATCH_IN(ev[7]), .T2_OVF_IN(ev[6]), .T2_BOTTOM_IN(ev[8]), .T2_PWM_IN(t2p), .T1_CAPTURE_IN(ev[5]),
		.T1_CMPA_MATCH_IN(ev[4]), .T1_CMPB_MATCH_IN(ev[3]), .T1_OVF_IN(ev[2]), .T1_BOTTOM_IN(ev[9]),
		.T1_PWM_IN(t1p), .T0_OVF_IN(ev[0]), .EXT_IRQ_PIN_0_IN(p0), .EXT_IRQ_PIN_1_IN(p1), .INSTR_DONE_IN(idone),
		.RETI_IN(reti), .SLEEP_INSTR_IN(sl), .IRQ_PENDING_OUT(pend), .VECTOR_FETCH_OUT(fet),
		.VECTOR_ADDR_OUT(vaddr), .STACK_PUSH_OUT(push), .STACK_POP_OUT(pop), .GLOBAL_IRQ_EN_OUT(gie),
		.SLEEP_ACTIVE_OUT(slp), .SLEEP_MODE_OUT(smode));
	irq_core_model irq_core_model_i (.clk_in(clk), .arst_n_in(rst_n), .fetch_in(fet), .instr_done_out(idone),
		.reti_out(reti));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk);
		awa <= a; wd <= {24'h000000, d}; awv <= 1'h1; wv <= 1'h1; br <= 1'h1;
		@(negedge clk);
		while (!(awr && wrdy)) @(negedge clk);
		@(posedge clk);
		awv <= 1'h0; wv <= 1'h0;
		@(negedge clk);
		while (!bv) @(negedge clk);
		chk("bresp", bresp, er);
		@(posedge clk);
		br <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		@(posedge clk);
		ara <= a; arv <= 1'h1; rr <= 1'h1;
		@(negedge clk);
		while (!arr) @(negedge clk);
		@(posedge clk);
		arv <= 1'h0;
		@(negedge clk);
		while (!rv) @(negedge clk);
		chk("rdata", rdata, {24'h000000, e});
		chk("rresp", rresp, er);
		@(posedge clk);
		rr <= 1'h0;
	endtask
	task automatic pulse(input logic [9:0] m);
		@(posedge clk); ev <= m;
		@(posedge clk); ev <= 10'h000;
	endtask
	task automatic t_regs;
		rd(8'hD4, 8'h00, 2'h0);
		rd(8'hE0, 8'h00, 2'h0);
		wr(8'hD4, 8'hFF, 2'h0); rd(8'hD4, 8'h7F, 2'h0);
		wr(8'hE4, 8'hFF, 2'h0); rd(8'hE4, 8'hFD, 2'h0);
		wr(8'hE4, 8'h00, 2'h0); wr(8'hD4, 8'h00, 2'h0);
		wr(8'h10, 8'h55, 2'h2); rd(8'h10, 8'h00, 2'h2);
		$display("t_regs done");
	endtask
	task automatic t_flags;
		for (int i = 0; i < 8; i++) begin
			if (i == 1) continue;
			pulse(10'h001 << i); rd(8'hE0, 8'h01 << i, 2'h0);
			wr(8'hE0, 8'h01 << i, 2'h0); rd(8'hE0, 8'h00, 2'h0);
		end
		pulse(10'h080); wr(8'hE0, 8'h00, 2'h0); rd(8'hE0, 8'h80, 2'h0);
		@(posedge clk); ev <= 10'h090;
		repeat (3) @(posedge clk);
		wr(8'hE0, 8'h90, 2'h0); rd(8'hE0, 8'h00, 2'h0);
		@(posedge clk); ev <= 10'h000; t1p <= 1'h1; t2p <= 1'h1;
		pulse(10'h044); rd(8'hE0, 8'h00, 2'h0);
		pulse(10'h300); rd(8'hE0, 8'h44, 2'h0);
		wr(8'hE0, 8'h44, 2'h0);
		@(posedge clk); t1p <= 1'h0; t2p <= 1'h0;
		$display("t_flags done");
	endtask
	task automatic t_sleep;
		wr(8'hE4, 8'h01, 2'h0);
		for (int k = 0; k < 4; k++) begin
			wr(8'hD4, 8'h40 | 8'(k << 4), 2'h0);
			@(posedge clk); sl <= 1'h1;
			@(posedge clk); sl <= 1'h0;
			@(negedge clk);
			chk("asleep", slp, 1'h1);
			chk("sleep mode", smode, k[1:0]);
			pulse(10'h001);
			repeat (3) @(negedge clk);
			chk("woken", slp, 1'h0);
			wr(8'hE0, 8'h01, 2'h0);
		end
		wr(8'hD4, 8'h00, 2'h0);
		@(posedge clk); sl <= 1'h1;
		@(posedge clk); sl <= 1'h0;
		@(negedge clk);
		chk("not armed", slp, 1'h0);
		wr(8'hE4, 8'h00, 2'h0);
		$display("t_sleep done");
	endtask
	task automatic t_ext;
		wr(8'hEC, 8'h40, 2'h0); wr(8'hD4, 8'h02, 2'h0);
		@(posedge clk); p0 <= 1'h0;
		repeat (6) @(posedge clk);
		rd(8'hE8, 8'h40, 2'h0); wr(8'hE8, 8'h40, 2'h0);
		wr(8'hD4, 8'h03, 2'h0); rd(8'hE8, 8'h00, 2'h0);
		@(posedge clk); p0 <= 1'h1;
		repeat (6) @(posedge clk);
		rd(8'hE8, 8'h40, 2'h0); wr(8'hE8, 8'h40, 2'h0);
		wr(8'hEC, 8'h80, 2'h0); wr(8'hD4, 8'h00, 2'h0);
		@(posedge clk); p1 <= 1'h0;
		repeat (20) @(negedge clk);
		chk("level request", pend, 1'h1);
		@(posedge clk); p1 <= 1'h1;
		repeat (6) @(negedge clk);
		chk("level released", pend, 1'h0);
		wr(8'hEC, 8'h00, 2'h0); rd(8'hE8, 8'h00, 2'h0);
		$display("t_ext done");
	endtask
	task automatic wait_fetch(input logic [3:0] e);
		@(negedge clk);
		while (!fet) @(negedge clk);
		chk("vector", vaddr, e);
		chk("global enable", gie, 1'h0);
	endtask
	task automatic t_vector;
		wr(8'hE4, 8'h0D, 2'h0);
		pulse(10'h00D); rd(8'hE0, 8'h0D, 2'h0);
		wr(8'hFC, 8'h80, 2'h0);
		wait_fetch(4'h7);
		rd(8'hE0, 8'h05, 2'h0);
		wait_fetch(4'h8);
		wait_fetch(4'h9);
		repeat (20) @(negedge clk);
		chk("enable restored", gie, 1'h1);
		rd(8'hE0, 8'h00, 2'h0);
		$display("t_vector done");
	endtask
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#200000;
		err_count++;
		tally_and_finish;
	end
	initial begin
		err_count = 0; checked = 0; rst_n = 1'h0;
		awv = 1'h0; wv = 1'h0; br = 1'h0; arv = 1'h0; rr = 1'h0; sl = 1'h0; t1p = 1'h0; t2p = 1'h0;
		p0 = 1'h1; p1 = 1'h1; awa = 8'h00; ara = 8'h00; wd = 32'h00000000; ev = 10'h000;
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		t_regs; t_flags; t_sleep; t_ext; t_vector;
		tally_and_finish;
	end
endmodule
bind irq_flags_vectoring_sleep_ctrl irq_ctrl_assertions irq_ctrl_assertions_i (.CLK_SYS_IN(CLK_SYS_IN),
	.ARST_N_IN(ARST_N_IN), .AWVALID_IN(AWVALID_IN), .AWREADY_OUT(AWREADY_OUT), .BVALID_OUT(BVALID_OUT),
	.BREADY_IN(BREADY_IN), .BRESP_OUT(BRESP_OUT), .ARVALID_IN(ARVALID_IN), .ARREADY_OUT(ARREADY_OUT),
	.RVALID_OUT(RVALID_OUT), .RDATA_OUT(RDATA_OUT), .VECTOR_FETCH_OUT(VECTOR_FETCH_OUT),
	.VECTOR_ADDR_OUT(VECTOR_ADDR_OUT), .STACK_PUSH_OUT(STACK_PUSH_OUT), .STACK_POP_OUT(STACK_POP_OUT),
	.GLOBAL_IRQ_EN_OUT(GLOBAL_IRQ_EN_OUT), .RETI_IN(RETI_IN), .INSTR_DONE_IN(INSTR_DONE_IN),
	.SLEEP_INSTR_IN(SLEEP_INSTR_IN), .SLEEP_ACTIVE_OUT(SLEEP_ACTIVE_OUT), .IRQ_PENDING_OUT(IRQ_PENDING_OUT));
